/* File: rtl/smhs_map.svh */
// Offsets, field positions and reset values for the strap decode block
`ifndef SMHS_MAP_SVH
`define SMHS_MAP_SVH
`define SMHS_CLK_CTRL_ADDR 8'h56
`define SMHS_CLK_CTRL_BIT 7
`define SMHS_LED_MODE_REG 8'h0B
`define SMHS_LED_MODE_HI 5
`define SMHS_LED_MODE_LO 4
`define SMHS_IFACE_MII 2'h0
`define SMHS_IFACE_RMII 2'h1
`define SMHS_IFACE_GMII 2'h2
`define SMHS_IFACE_RGMII 2'h3
`define SMHS_STRAP_RESET 7'h7E
`define SMHS_SYNC_STAGES 2
`endif

/* File: rtl/smhs_pkg.sv */
// Types shared by the strap decode block
package smhs_pkg;
	typedef enum logic [1:0] {
		SMHS_MII = 2'h0,
		SMHS_RMII = 2'h1,
		SMHS_GMII = 2'h2,
		SMHS_RGMII = 2'h3
	} smhs_iface_t;
	typedef enum logic [2:0] {
		SMHS_ST_RESET = 3'h1,
		SMHS_ST_CAPTURE = 3'h2,
		SMHS_ST_RUN = 3'h4
	} smhs_state_t;
endpackage

/* File: rtl/smhs_sync.sv */
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module smhs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	always_comb
	begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/smhs_top.sv */
// Strap capture and decode of uplink mode, clocking and host bus selection
//
// What this block does
// - GMII or MII: high role strap selects MAC role, low selects PHY role.
// - PHY role turns carrier sense and collision into outputs, and in MII the MII clocks too.
// - RMII: high role strap drives 50 MHz reference out; low takes external clock.
// - Register 0x56 bit 7 may override the RMII clock choice.
// - High reference strap enables the 25 MHz clock output; low disables it.
// - High PLL strap keeps crystal clocking; low uses transmit clock in RMII normal.
// - High speed strap gives 1 Gbps in GMII/RGMII; registers may change it.
// - Low serial strap selects SPI slave; high selects MDC/MDIO.
// - SPI uses data pin as input and separate read pin; MDIO data is two-way.
// - Chip select high deselects and floats the serial read output.
// - A falling chip select edge starts an SPI transfer.
// - Hardware reset low resets the whole block except the pin synchronisers.
// - LED function on strap pins after reset follows global register 11 bits 5:4.
// - Straps are sampled during reset.
// - Strap pins are inputs during reset and for two cycles after release, outputs otherwise.
// - Interface strap: 00 MII, 01 RMII, 10 GMII, 11 RGMII.
`include "smhs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module smhs_top
	import smhs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Strap pins, inputs during reset
	input wire logic [1:0] uplink_iface_strap,
	input wire logic uplink_role_strap,
	input wire logic refclk_out_strap,
	input wire logic pll_source_strap,
	input wire logic uplink_speed_strap,
	input wire logic serial_read_strap,
	output logic strap_pins_oe_n,
	// Indicator data and function select for the shared pins
	input wire logic [7:0] cfg_reg_addr,
	input wire logic [7:0] cfg_reg_wdata,
	input wire logic cfg_reg_wr,
	input wire logic [5:0] led_state,
	output logic [5:0] led_pins_out,
	output logic [1:0] led_mode,
	// Speed override from internal registers
	input wire logic speed_override_en,
	input wire logic speed_override_gbps,
	// Decoded uplink configuration
	output smhs_iface_t uplink_iface,
	output logic uplink_gigabit_mac,
	output logic gigabit_phy_role,
	output logic crs_col_oe_n,
	output logic mii_clk_oe_n,
	output logic rmii_clock_mode,
	output logic uplink_rx_clock_oe_n,
	output logic ref_clock_output,
	output logic pll_from_tx_clock,
	output logic uplink_gbps,
	// Host serial bus
	input wire logic host_sclk,
	input wire logic host_select_n,
	input wire logic host_data_in,
	input wire logic host_read_bit,
	input wire logic host_mdio_drive,
	input wire logic host_mdio_bit,
	output logic host_spi_mode,
	output logic host_data_oe_n,
	output logic host_data_out,
	output logic serial_read_out,
	output logic serial_read_oe_n,
	output logic spi_xfer_start,
	output logic host_sclk_rise,
	output logic host_data_sync
);
	// ****************************************************
	// Synchronisers for pins
	// ****************************************************
	logic [9:0] strap_raw;
	logic [9:0] strap_sync;
	logic [2:0] host_sync;

	assign strap_raw = {uplink_iface_strap, uplink_role_strap, refclk_out_strap,
		pll_source_strap, uplink_speed_strap, serial_read_strap, 3'h0};

	smhs_sync #(.WIDTH(10)) u_strap_sync (
		.core_clk(core_clk),
		.rst_n(1'b1),
		.async_in(strap_raw),
		.sync_out(strap_sync)
	);

	// Runs through reset so the idle-high select shows its real level at release
	smhs_sync #(.WIDTH(3)) u_host_sync (
		.core_clk(core_clk),
		.rst_n(1'b1),
		.async_in({host_sclk, host_select_n, host_data_in}),
		.sync_out(host_sync)
	);

	// ****************************************************
	// Strap capture
	// ****************************************************
	smhs_state_t state;
	smhs_state_t next_state;
	logic [6:0] straps;
	logic [6:0] next_straps;
	logic rmii_clk_ovr_en;
	logic rmii_clk_ovr;
	logic next_rmii_clk_ovr_en;
	logic next_rmii_clk_ovr;
	logic [1:0] next_led_mode;

	always_comb
	begin
		next_state = state;
		next_straps = straps;
		next_rmii_clk_ovr_en = rmii_clk_ovr_en;
		next_rmii_clk_ovr = rmii_clk_ovr;
		next_led_mode = led_mode;
		case (state)
			SMHS_ST_RESET:
			begin
				next_state = SMHS_ST_CAPTURE;
			end
			SMHS_ST_CAPTURE:
			begin
				next_straps = strap_sync[9:3];
				next_state = SMHS_ST_RUN;
			end
			SMHS_ST_RUN:
			begin
				if (cfg_reg_wr && cfg_reg_addr == `SMHS_CLK_CTRL_ADDR)
				begin
					next_rmii_clk_ovr_en = 1'b1;
					next_rmii_clk_ovr = cfg_reg_wdata[`SMHS_CLK_CTRL_BIT];
				end
				if (cfg_reg_wr && cfg_reg_addr == `SMHS_LED_MODE_REG)
					next_led_mode = cfg_reg_wdata[`SMHS_LED_MODE_HI:`SMHS_LED_MODE_LO];
			end
			default:
			begin
				next_state = SMHS_ST_RESET;
			end
		endcase
	end

	// Straps keep sampling through reset; the value kept is the one sampled on the last edge in reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state <= SMHS_ST_RESET;
			straps <= `SMHS_STRAP_RESET;
			rmii_clk_ovr_en <= 1'b0;
			rmii_clk_ovr <= 1'b0;
			led_mode <= 2'h0;
		end
		else
		begin
			state <= next_state;
			straps <= next_straps;
			rmii_clk_ovr_en <= next_rmii_clk_ovr_en;
			rmii_clk_ovr <= next_rmii_clk_ovr;
			led_mode <= next_led_mode;
		end
	end

	// ****************************************************
	// Decode
	// ****************************************************
	logic run;
	logic rmii_clk;
	assign run = (state == SMHS_ST_RUN);
	assign strap_pins_oe_n = !run;
	assign led_pins_out = run ? led_state : 6'h00;
	assign uplink_iface = smhs_iface_t'(straps[6:5]);
	assign uplink_gigabit_mac = straps[4];
	assign gigabit_phy_role = !straps[4] && (uplink_iface == SMHS_MII
		|| uplink_iface == SMHS_GMII);
	assign crs_col_oe_n = !gigabit_phy_role;
	assign mii_clk_oe_n = !(gigabit_phy_role && uplink_iface == SMHS_MII);
	assign rmii_clk = rmii_clk_ovr_en ? rmii_clk_ovr : straps[4];
	assign rmii_clock_mode = (uplink_iface == SMHS_RMII) && rmii_clk;
	assign uplink_rx_clock_oe_n = !(rmii_clock_mode || uplink_iface == SMHS_GMII
		|| uplink_iface == SMHS_RGMII || !mii_clk_oe_n);
	assign ref_clock_output = straps[3];
	assign pll_from_tx_clock = (uplink_iface == SMHS_RMII) && !rmii_clk
		&& !straps[2];
	assign uplink_gbps = (speed_override_en ? speed_override_gbps : straps[1])
		&& (uplink_iface == SMHS_GMII || uplink_iface == SMHS_RGMII);
	assign host_spi_mode = !straps[0];

	// ****************************************************
	// Host bus pins
	// ****************************************************
	logic sclk_d;
	logic sel_d;
	logic next_sclk_d;
	logic next_sel_d;
	logic next_spi_xfer_start;
	logic next_host_sclk_rise;
	logic next_host_data_sync;

	always_comb
	begin
		next_sclk_d = host_sync[2];
		next_sel_d = host_sync[1];
		next_spi_xfer_start = run && host_spi_mode && sel_d && !host_sync[1];
		next_host_sclk_rise = run && !sclk_d && host_sync[2];
		next_host_data_sync = host_sync[0];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sclk_d <= 1'b0;
			sel_d <= 1'b1;
			spi_xfer_start <= 1'b0;
			host_sclk_rise <= 1'b0;
			host_data_sync <= 1'b0;
		end
		else
		begin
			sclk_d <= next_sclk_d;
			sel_d <= next_sel_d;
			spi_xfer_start <= next_spi_xfer_start;
			host_sclk_rise <= next_host_sclk_rise;
			host_data_sync <= next_host_data_sync;
		end
	end

	assign serial_read_out = host_read_bit;
	assign serial_read_oe_n = !(run && host_spi_mode && !host_sync[1]);
	assign host_data_out = host_mdio_bit;
	assign host_data_oe_n = !(run && !host_spi_mode && host_mdio_drive);
endmodule
`default_nettype wire

/* File: test/smhs_top_props.sv */
// Port-level assertions for the strap decode block
`timescale 1ns/1ps
`default_nettype none
module smhs_top_props
	import smhs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Decoded configuration
	input wire logic strap_pins_oe_n,
	input wire smhs_iface_t uplink_iface,
	input wire logic gigabit_phy_role,
	input wire logic crs_col_oe_n,
	input wire logic rmii_clock_mode,
	input wire logic pll_from_tx_clock,
	// Host serial bus
	input wire logic host_select_n,
	input wire logic host_spi_mode,
	input wire logic host_data_oe_n,
	input wire logic serial_read_oe_n,
	input wire logic spi_xfer_start
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_OE_RELEASE: assert property ($rose(rst_n) |-> strap_pins_oe_n ##1 strap_pins_oe_n
		##1 !strap_pins_oe_n) else $error("strap pins not released two cycles after reset");
	AST_HOLD: assert property (!strap_pins_oe_n && $past(!strap_pins_oe_n)
		|-> $stable({uplink_iface, gigabit_phy_role, host_spi_mode})) else $error("straps moved");
	AST_PHY_IFACE: assert property (gigabit_phy_role
		|-> uplink_iface inside {SMHS_MII, SMHS_GMII}) else $error("phy role outside mii or gmii");
	AST_PHY_PINS: assert property (gigabit_phy_role |-> !crs_col_oe_n)
		else $error("phy role without carrier pins driven");
	AST_RMII_CLK: assert property (rmii_clock_mode |-> uplink_iface == SMHS_RMII)
		else $error("clock mode outside rmii");
	AST_PLL_SRC: assert property (pll_from_tx_clock
		|-> uplink_iface == SMHS_RMII && !rmii_clock_mode)
		else $error("pll source from tx clock outside rmii normal mode");
	AST_DESELECT: assert property (host_select_n [*4] |-> serial_read_oe_n)
		else $error("read output driven while deselected");
	AST_READ_SPI: assert property (!serial_read_oe_n |-> host_spi_mode)
		else $error("read output driven in mdio mode");
	AST_DATA_DIR: assert property (host_spi_mode |-> host_data_oe_n)
		else $error("data pin driven in spi mode");
	AST_START: assert property (host_spi_mode && !strap_pins_oe_n && $fell(host_select_n)
		|-> ##[2:4] spi_xfer_start) else $error("no transfer start after select fell");
	AST_START_PULSE: assert property (spi_xfer_start |-> host_spi_mode ##1 !spi_xfer_start)
		else $error("bad transfer start pulse");
endmodule
bind smhs_top smhs_top_props smhs_top_props_inst (.core_clk, .rst_n, .strap_pins_oe_n,
	.uplink_iface, .gigabit_phy_role, .crs_col_oe_n, .rmii_clock_mode, .pll_from_tx_clock,
	.host_select_n, .host_spi_mode, .host_data_oe_n, .serial_read_oe_n, .spi_xfer_start);
`default_nettype wire

/* File: test/smhs_host_model.sv */
// Host processor model on the management serial pins
`timescale 1ns/1ps
`default_nettype none
module smhs_host_model (
	// Serial pins; select and data idle at pull-up level, clock idles low
	output logic host_sclk,
	output logic host_select_n,
	output logic host_data_in
);
	initial
	begin
		host_sclk = 1'b0;
		host_select_n = 1'b1;
		host_data_in = 1'b1;
	end
	task automatic frame(input logic [7:0] b);
		host_select_n = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			host_data_in = b[i];
			#80 host_sclk = 1'b1;
			#80 host_sclk = 1'b0;
		end
		#80 host_select_n = 1'b1;
		host_data_in = 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: test/smhs_top_tb_top.sv */
// Self-checking bench for the strap decode block
`timescale 1ns/1ps
`default_nettype none
module smhs_top_tb_top;
	import smhs_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, cfg_reg_wr = 1'b0;
	logic speed_override_en = 1'b0, speed_override_gbps = 1'b0;
	logic [6:0] straps = 7'h7F;
	logic [7:0] cfg_reg_addr = 8'h00, cfg_reg_wdata = 8'h00, pins = 8'h5A;
	wire logic host_sclk, host_select_n, host_data_in;
	logic strap_pins_oe_n, gigabit_phy_role, rmii_clock_mode, ref_clock_output;
	logic pll_from_tx_clock, uplink_gbps, host_spi_mode, spi_xfer_start, host_sclk_rise;
	logic [1:0] led_mode;
	smhs_iface_t uplink_iface;
	logic [5:0] led_pins_out;
	logic uplink_gigabit_mac, crs_col_oe_n, mii_clk_oe_n, uplink_rx_clock_oe_n;
	logic serial_read_out, serial_read_oe_n, host_data_oe_n, host_data_out, host_data_sync;
	logic [7:0] rx_byte = 8'h00;
	int err_count = 0, n_checks = 0, cyc = 0, nspi = 0, nrise = 0, nrd = 0;
	logic [7:0] exp_q[$];
	logic [7:0] pin_q[$];
	smhs_top smhs_top_inst (.core_clk, .rst_n, .uplink_iface_strap(straps[6:5]),
		.uplink_role_strap(straps[4]), .refclk_out_strap(straps[3]),
		.pll_source_strap(straps[2]), .uplink_speed_strap(straps[1]),
		.serial_read_strap(straps[0]), .strap_pins_oe_n, .cfg_reg_addr, .cfg_reg_wdata,
		.cfg_reg_wr, .led_state(pins[7:2]), .led_pins_out, .led_mode, .speed_override_en,
		.speed_override_gbps, .uplink_iface, .uplink_gigabit_mac, .gigabit_phy_role,
		.crs_col_oe_n, .mii_clk_oe_n, .rmii_clock_mode, .uplink_rx_clock_oe_n,
		.ref_clock_output, .pll_from_tx_clock, .uplink_gbps, .host_sclk, .host_select_n,
		.host_data_in, .host_read_bit(pins[1]), .host_mdio_drive(pins[0]),
		.host_mdio_bit(pins[2]), .host_spi_mode, .host_data_oe_n, .host_data_out,
		.serial_read_out, .serial_read_oe_n, .spi_xfer_start, .host_sclk_rise,
		.host_data_sync);
	smhs_host_model smhs_host_model_inst (.host_sclk, .host_select_n, .host_data_in);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] cfg(input logic [6:0] s, input logic oe, input logic og);
		logic rm;
		rm = s[6:5] == 2'h1;
		return {s[6:5], !s[4] && !s[5], rm && s[4], s[3], rm && !s[4] && !s[2],
			s[6] && (oe ? og : s[1]), !s[0]};
	endfunction
	// Expected pin directions: {mac role, crs/col oe_n, mii clock oe_n, rx clock oe_n}
	function automatic logic [7:0] pdir(input logic [6:0] s);
		logic phy;
		phy = !s[4] && !s[5];
		return {4'h0, s[4], !phy, !(phy && !s[6]),
			!((s[6:5] == 2'h1 && s[4]) || s[6] || (phy && !s[6]))};
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_reg_addr <= a;
		cfg_reg_wdata <= d;
		cfg_reg_wr <= 1'b1;
		@(posedge core_clk);
		cfg_reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	// Random indicator and read data, plus the hang limit
	always @(posedge core_clk)
	begin
		pins <= lfsr(pins);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			give_verdict();
		end
	end
	// Watcher: decoded straps appear when the pins turn to outputs
	always @(negedge core_clk)
	begin
		if (strap_pins_oe_n === 1'b0 && exp_q.size() > 0)
		begin
			check("config", exp_q.pop_front(), {uplink_iface, gigabit_phy_role,
				rmii_clock_mode, ref_clock_output, pll_from_tx_clock, uplink_gbps,
				host_spi_mode});
			check("pin_dir", pin_q.pop_front(), {4'h0, uplink_gigabit_mac, crs_col_oe_n,
				mii_clk_oe_n, uplink_rx_clock_oe_n});
		end
		if (cyc > 4)
		begin
			check("led_pins_out", strap_pins_oe_n ? 8'h00 : 8'(pins[7:2]),
				8'(led_pins_out));
			check("serial_read_out", 8'(pins[1]), 8'(serial_read_out));
			check("host_data_out", 8'(pins[2]), 8'(host_data_out));
			check("host_data_oe_n", 8'(strap_pins_oe_n || host_spi_mode || !pins[0]),
				8'(host_data_oe_n));
		end
		nspi += (spi_xfer_start === 1'b1);
		nrise += (host_sclk_rise === 1'b1);
		nrd += (serial_read_oe_n === 1'b0);
		if (host_sclk_rise === 1'b1)
			rx_byte = {rx_byte[6:0], host_data_sync};
	end
	initial
	begin
		logic [7:0] r;
		logic [6:0] s;
		int spi0, rise0, rd0;
		r = 8'h5A;
		for (int i = 0; i < 8; i++)
		begin
			r = lfsr(r);
			s = {i[1:0], r[4:0]};
			@(posedge core_clk);
			rst_n <= 1'b0;
			straps <= s;
			speed_override_en <= i[2];
			speed_override_gbps <= r[7];
			repeat (i == 0 ? 16 : 4) @(posedge core_clk);
			exp_q.push_back(cfg(s, i[2], r[7]));
			pin_q.push_back(pdir(s));
			rst_n <= 1'b1;
			repeat (4) @(posedge core_clk);
			straps <= ~s;
			spi0 = nspi;
			rise0 = nrise;
			rd0 = nrd;
			#3 smhs_host_model_inst.frame(r);
			repeat (8) @(posedge core_clk);
			check("spi_xfer_start", 8'(!s[0]), 8'(nspi - spi0));
			check("host_sclk_rise", 8'h08, 8'(nrise - rise0));
			check("host_data_sync", r, rx_byte);
			check("read_oe_cycles", s[0] ? 8'h00 : 8'h44, 8'(nrd - rd0));
			check("serial_read_oe_n", 8'h01, 8'(serial_read_oe_n));
			wr(8'h0B, r);
			wr(8'h56, {~s[4], 7'h00});
			@(negedge core_clk);
			check("led_mode", 8'(r[5:4]), 8'(led_mode));
			check("rmii_clock_mode", 8'(s[6:5] == 2'h1 && !s[4]), 8'(rmii_clock_mode));
			$display("test %0d done", i);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
